// file: rtl/sac_ctrl.sv
// Sequence control for a four-channel simultaneous-sampling converter.
// What this block does
// - Busy rises on start, falls after last channel.
// - First-data high while pointer selects first result.
// - Start edge holds all track/holds, begins converting.
// - Selection captured on start edge, then frozen.
// - Strobes obeyed only while chip select low.
// - Data outputs driven only with read and select low.
// - Write rising edge loads low data into register.
// - Source select: 0 pins, 1 register.
// - Standby low enters power save.
// - Clock select: 0 internal, 1 external clock.
// - Each conversion takes fourteen conversion clocks.
// - One low end-of-conversion pulse per channel.
// - Bit 0 is first channel, bit 3 fourth.
`timescale 1ns/100ps
`include "sac_map.svh"

module sac_ctrl
  import sac_pkg::*;
(
  input  wire logic        i_clk_sys,             // System clock, 100 MHz.
  input  wire logic        i_rst,                 // Asynchronous reset, active high.
  input  wire logic        i_conversion_start_in, // Start pin, rising edge acts.
  input  wire logic        i_cs_n,                // Chip select, active low.
  input  wire logic        i_rd_n,                // Read strobe, active low.
  input  wire logic        i_wr_n,                // Write strobe, active low.
  input  wire logic [3:0]  i_low_data_lines,      // Data lines 0 to 3, input side.
  input  wire logic [3:0]  i_hw_channel_pins,     // Hardware channel selection.
  input  wire logic        i_seq_source_select,   // 0 pins, 1 register.
  input  wire logic        i_standby_n,           // Low requests standby.
  input  wire logic        i_clock_source_select, // 0 internal, 1 external.
  input  wire logic        i_external_conv_clock, // External conversion clock.
  input  wire logic [11:0] i_conv_result,         // Result from the converter core.
  output logic             o_busy,                // Sequence in progress.
  output logic             o_eoc_n,               // End-of-conversion pulse, low.
  output logic             o_first_data_flag,     // Pointer on first result.
  output logic             o_hold,                // All track/holds in hold.
  output logic [1:0]       o_conv_ch,             // Channel now converting.
  output logic [11:0]      o_data,                // Parallel data out.
  output logic             o_data_oe,             // Data output enable.
  output logic             o_power_save           // Standby state active.
);

  localparam logic [3:0] CONV_LAST = 4'(`SAC_CONV_CLKS - 1);
  localparam logic [4:0] EOC_LAST  = 5'(`SAC_EOC_CYC - 1);
  localparam logic [3:0] DIV_LAST  = 4'(`SAC_INT_DIV - 1);

  // Lowest set bit of a mask: {valid, index}; bit 0 is the first channel.
  function automatic logic [2:0] first_sel(input logic [3:0] m);
    logic [2:0] r;
    r = 3'h0;
    for (int i = `SAC_NUM_CH - 1; i >= 0; i--) begin
      if (m[i]) begin
        r = {1'b1, 2'(i)};
      end
    end
    return r;
  endfunction

  // =============================================================
  // Pin synchroniser
  sac_pins_t pin_raw;
  sac_pins_t pin_m_r;
  sac_pins_t pin_s_r;
  sac_pins_t pin_d_r;

  // All pins enter one packed bundle.
  assign pin_raw = '{conversion_start_in: i_conversion_start_in, cs_n: i_cs_n, rd_n: i_rd_n,
                     wr_n: i_wr_n, hs_sel: i_seq_source_select,
                     standby_n: i_standby_n, clk_sel: i_clock_source_select,
                     ext_clk: i_external_conv_clock, hw_ch: i_hw_channel_pins,
                     low_data: i_low_data_lines};

  // Two stages for metastability, a third only for edge detection.
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      pin_m_r <= `SAC_PINS_IDLE;
      pin_s_r <= `SAC_PINS_IDLE;
      pin_d_r <= `SAC_PINS_IDLE;
    end else begin
      pin_m_r <= pin_raw;
      pin_s_r <= pin_m_r;
      pin_d_r <= pin_s_r;
    end
  end

  // =============================================================
  // Event decoding
  logic       start_evt;
  logic       wr_evt;
  logic       rd_end_evt;
  logic       ext_tick;
  logic       div_tick;
  logic       conv_tick;
  logic       standby_n_ok;
  logic [3:0] sel_src;
  logic [3:0] chsel_r;

  assign start_evt  = pin_s_r.conversion_start_in & ~pin_d_r.conversion_start_in;
  assign wr_evt     = pin_s_r.wr_n & ~pin_d_r.wr_n & ~pin_s_r.cs_n & pin_s_r.rd_n;
  assign rd_end_evt = pin_s_r.rd_n & ~pin_d_r.rd_n & ~pin_s_r.cs_n;
  assign ext_tick   = pin_s_r.ext_clk & ~pin_d_r.ext_clk;
  assign conv_tick  = pin_s_r.clk_sel ? ext_tick : div_tick;
  assign standby_n_ok    = pin_s_r.standby_n;
  assign sel_src    = pin_s_r.hs_sel ? chsel_r : pin_s_r.hw_ch;

  // =============================================================
  // Internal conversion clock divider, runs only while awake.
  logic [3:0] div_cnt_r;

  assign div_tick = standby_n_ok & (div_cnt_r == DIV_LAST);

  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      div_cnt_r <= 4'h0;
    end else begin
      div_cnt_r <= (div_tick || !standby_n_ok) ? 4'h0 : div_cnt_r + 4'h1;
    end
  end

  // Channel select register, loaded on the write strobe's rising edge.
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      chsel_r <= `SAC_CHSEL_RST;
    end else if (wr_evt) begin
      chsel_r <= pin_s_r.low_data;
    end
  end

  // =============================================================
  // Sequencer
  sac_state_t state_r, state_nxt;
  logic [3:0] seq_r, seq_nxt;
  logic [3:0] left_r, left_nxt;
  logic [1:0] ch_r, ch_nxt;
  logic [3:0] tick_r, tick_nxt;
  logic [4:0] eoc_cnt_r, eoc_cnt_nxt;
  logic       busy_nxt;
  logic       hold_nxt;
  logic       eocn_nxt;
  logic       res_we;
  logic [2:0] first_start;
  logic [2:0] first_next;
  logic [3:0] left_clr;

  assign first_start = first_sel(sel_src);
  assign left_clr    = left_r & ~(4'h1 << ch_r);
  assign first_next  = first_sel(left_clr);

  // Next-state logic; standby aborts any sequence.
  always_comb begin
    state_nxt   = state_r;
    seq_nxt     = seq_r;
    left_nxt    = left_r;
    ch_nxt      = ch_r;
    tick_nxt    = tick_r;
    eoc_cnt_nxt = eoc_cnt_r;
    busy_nxt    = o_busy;
    hold_nxt    = o_hold;
    eocn_nxt    = 1'b1;
    res_we      = 1'b0;
    if (!standby_n_ok) begin
      state_nxt = ST_IDLE;
      busy_nxt  = 1'b0;
      hold_nxt  = 1'b0;
    end else begin
      case (state_r)
        ST_IDLE: begin
          if (start_evt) begin
            seq_nxt  = sel_src;
            left_nxt = sel_src;
            busy_nxt = 1'b1;
            hold_nxt = 1'b1;
            ch_nxt   = first_start[1:0];
            tick_nxt = 4'h0;
            state_nxt = first_start[2] ? ST_CONV : ST_END;
          end
        end
        ST_CONV: begin
          if (conv_tick) begin
            if (tick_r == CONV_LAST) begin
              res_we      = 1'b1;
              eocn_nxt    = 1'b0;
              eoc_cnt_nxt = 5'h00;
              state_nxt   = ST_EOC;
            end else begin
              tick_nxt = tick_r + 4'h1;
            end
          end
        end
        ST_EOC: begin
          eocn_nxt = 1'b0;
          eoc_cnt_nxt = eoc_cnt_r + 5'h01;
          if (eoc_cnt_r == EOC_LAST) begin
            eocn_nxt  = 1'b1;
            left_nxt  = left_clr;
            ch_nxt    = first_next[1:0];
            tick_nxt  = 4'h0;
            state_nxt = first_next[2] ? ST_CONV : ST_END;
          end
        end
        ST_END: begin
          busy_nxt  = 1'b0;
          hold_nxt  = 1'b0;
          state_nxt = ST_IDLE;
        end
        default: begin
          state_nxt = ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      state_r   <= ST_IDLE;
      seq_r     <= 4'h0;
      left_r    <= 4'h0;
      ch_r      <= 2'h0;
      tick_r    <= 4'h0;
      eoc_cnt_r <= 5'h00;
      o_busy    <= 1'b0;
      o_hold    <= 1'b0;
      o_eoc_n   <= 1'b1;
    end else begin
      state_r   <= state_nxt;
      seq_r     <= seq_nxt;
      left_r    <= left_nxt;
      ch_r      <= ch_nxt;
      tick_r    <= tick_nxt;
      eoc_cnt_r <= eoc_cnt_nxt;
      o_busy    <= busy_nxt;
      o_hold    <= hold_nxt;
      o_eoc_n   <= eocn_nxt;
    end
  end

  // =============================================================
  // Result store and read pointer
  logic [1:0]  wr_idx_r;
  logic [2:0]  nres_r;
  logic [1:0]  ptr_r;
  logic [1:0]  ptr_nxt;
  logic [11:0] mem_rdata;
  logic        idle_start;

  assign idle_start = start_evt & standby_n_ok & (state_r == ST_IDLE);
  assign ptr_nxt = idle_start ? 2'h0 :
                   !rd_end_evt ? ptr_r :
                   (({1'b0, ptr_r} + 3'h1) >= nres_r) ? 2'h0 : ptr_r + 2'h1;

  // Results are numbered in conversion order; each completed read advances.
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      wr_idx_r          <= 2'h0;
      nres_r            <= 3'h0;
      ptr_r             <= 2'h0;
      o_first_data_flag <= 1'b1;
    end else begin
      wr_idx_r          <= idle_start ? 2'h0 : (res_we ? wr_idx_r + 2'h1 : wr_idx_r);
      nres_r            <= idle_start ? 3'h0 : (res_we ? nres_r + 3'h1 : nres_r);
      ptr_r             <= ptr_nxt;
      o_first_data_flag <= (ptr_nxt == 2'h0);
    end
  end

  sac_result_mem u_mem (
    .i_clk_sys (i_clk_sys),
    .i_rst     (i_rst),
    .i_we      (res_we),
    .i_waddr   (wr_idx_r),
    .i_wdata   (i_conv_result),
    .i_raddr   (ptr_r),
    .o_rdata   (mem_rdata)
  );

  // Output drivers; data enabled only for a selected read.
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      o_data       <= 12'h000;
      o_data_oe    <= 1'b0;
      o_conv_ch    <= 2'h0;
      o_power_save <= 1'b0;
    end else begin
      o_data       <= mem_rdata;
      o_data_oe    <= ~pin_s_r.cs_n & ~pin_s_r.rd_n;
      o_conv_ch    <= ch_r;
      o_power_save <= ~standby_n_ok;
    end
  end

  // =============================================================
  // Assertions
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (i_rst);

  sequence s_last_tick;
    state_r == ST_CONV && conv_tick && tick_r == CONV_LAST && standby_n_ok;
  endsequence
  sequence s_eoc_pulse;
    !o_eoc_n [*8] ##1 o_eoc_n;
  endsequence

  property p_busy_start;
    idle_start |=> o_busy && o_hold;
  endproperty
  a_busy_start: assert property (p_busy_start) else $error("busy or hold missing");

  property p_hold_busy;
    o_busy |-> o_hold;
  endproperty
  a_hold_busy: assert property (p_hold_busy) else $error("busy without hold");

  property p_first;
    o_first_data_flag == (ptr_r == 2'h0);
  endproperty
  a_first: assert property (p_first) else $error("first-data flag wrong");

  property p_capture;
    idle_start |=> seq_r == $past(pin_s_r.hs_sel ? chsel_r : pin_s_r.hw_ch)
                   ##1 ($stable(seq_r) || $past(idle_start));
  endproperty
  a_capture: assert property (p_capture) else $error("selection not captured");

  property p_cs_gate;
    pin_s_r.cs_n |=> $stable(chsel_r);
  endproperty
  a_cs_gate: assert property (p_cs_gate) else $error("write without select");

  property p_oe;
    ##1 o_data_oe == $past(!pin_s_r.cs_n && !pin_s_r.rd_n);
  endproperty
  a_oe: assert property (p_oe) else $error("data enable wrong");

  property p_write;
    wr_evt |=> chsel_r == $past(pin_s_r.low_data);
  endproperty
  a_write: assert property (p_write) else $error("channel register not loaded");

  property p_standby;
    !standby_n_ok |=> state_r == ST_IDLE && !o_busy && o_power_save;
  endproperty
  a_standby: assert property (p_standby) else $error("standby not entered");

  property p_conv_len;
    s_last_tick |=> state_r == ST_EOC && !o_eoc_n;
  endproperty
  a_conv_len: assert property (p_conv_len) else $error("conversion length wrong");

  // Standby cuts a pulse short on purpose, so it lifts this check.
  property p_eoc;
    disable iff (i_rst || !standby_n_ok)
    $fell(o_eoc_n) |-> s_eoc_pulse;
  endproperty
  a_eoc: assert property (p_eoc) else $error("end pulse width wrong");

  property p_order;
    state_r == ST_EOC && eoc_cnt_r == EOC_LAST && first_next[2] && standby_n_ok
      |=> state_r == ST_CONV && ch_r > $past(ch_r);
  endproperty
  a_order: assert property (p_order) else $error("channel order wrong");

  property p_selected;
    state_r == ST_CONV |-> seq_r[ch_r];
  endproperty
  a_selected: assert property (p_selected) else $error("unselected channel");

endmodule // sac_ctrl

// file: rtl/sac_map.svh
// Timing counts, reset values and sizes of the sequence controller.
`ifndef SAC_MAP_SVH
`define SAC_MAP_SVH

// =============================================================
// Clock and timing
`define SAC_CLK_NS       10
`define SAC_EOC_MIN_NS   75
`define SAC_EOC_MAX_NS   180
`define SAC_EOC_CYC      ((`SAC_EOC_MIN_NS + `SAC_CLK_NS - 1) / `SAC_CLK_NS)
`define SAC_CONV_CLKS    14
`define SAC_INT_DIV      5

// =============================================================
// Reset values and sizes
`define SAC_PINS_IDLE    16'h7400
`define SAC_CHSEL_RST    4'hF
`define SAC_NUM_CH       4
`define SAC_RES_W        12

`endif

// file: rtl/sac_pkg.sv
// Types shared by the sequence controller files.
package sac_pkg;

  // Pin bundle, sampled as a whole through the synchroniser.
  typedef struct packed {
    logic       conversion_start_in;      // Conversion start.
    logic       cs_n;        // Chip select, active low.
    logic       rd_n;        // Read strobe, active low.
    logic       wr_n;        // Write strobe, active low.
    logic       hs_sel;      // Sequence source select.
    logic       standby_n;   // Standby, active low.
    logic       clk_sel;     // Clock source select.
    logic       ext_clk;     // External conversion clock.
    logic [3:0] hw_ch;       // Hardware channel pins.
    logic [3:0] low_data;    // Low data lines.
  } sac_pins_t;

  // Sequencer states, Gray along idle, convert, pulse, end.
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_CONV = 2'b01,
    ST_EOC  = 2'b11,
    ST_END  = 2'b10
  } sac_state_t;

endpackage

// file: rtl/sac_result_mem.sv
// Four-word result store with a registered read port.
`timescale 1ns/100ps
`include "sac_map.svh"

module sac_result_mem (
  input  wire logic        i_clk_sys,  // System clock.
  input  wire logic        i_rst,      // Asynchronous reset, active high.
  input  wire logic        i_we,       // Write enable.
  input  wire logic [1:0]  i_waddr,    // Write address.
  input  wire logic [11:0] i_wdata,    // Write data.
  input  wire logic [1:0]  i_raddr,    // Read address.
  output logic      [11:0] o_rdata     // Registered read data.
);

  logic [11:0] mem [0:`SAC_NUM_CH-1];

  // =============================================================
  // Storage array, written at the end of each channel conversion.
  always_ff @(posedge i_clk_sys) begin
    if (i_we) begin
      mem[i_waddr] <= i_wdata;
    end
  end

  // Read data leaves through a register.
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      o_rdata <= 12'h000;
    end else begin
      o_rdata <= mem[i_raddr];
    end
  end

endmodule // sac_result_mem

// file: testbench/sac_host_model.sv
// Host processor model that drives the parallel port of the sequence controller.
`timescale 1ns/100ps

module sac_host_model (
  input  wire logic       i_clk_sys,  // System clock.
  input  wire logic       i_data_oe,  // Device data output enable.
  output logic            o_cs_n,     // Chip select, active low.
  output logic            o_rd_n,     // Read strobe, active low.
  output logic            o_wr_n,     // Write strobe, active low.
  output logic [3:0]      o_low_data  // Low data lines toward the device.
);
  // =============================================================
  // Idle levels
  // The lines start idle; the data lines never rest on a stale value.
  initial begin
    o_cs_n = 1'b1;
    o_rd_n = 1'b1;
    o_wr_n = 1'b1;
    o_low_data = 4'hA;
  end

  // =============================================================
  // Write cycle
  // Data is held four clocks on each side of the write edge.
  task automatic write_sel(input logic [3:0] val, input logic sel);
    @(negedge i_clk_sys);
    o_cs_n = ~sel;
    o_low_data = val;
    o_wr_n = 1'b0;
    repeat (4) @(negedge i_clk_sys);
    o_wr_n = 1'b1;
    repeat (4) @(negedge i_clk_sys);
    o_cs_n = 1'b1;
    o_low_data = ~val;
  endtask

  // =============================================================
  // Read cycle
  // Reports the enable seen while reading and after release.
  task automatic read_sel(input logic sel, output logic oe_on, output logic oe_off);
    @(negedge i_clk_sys);
    o_wr_n = 1'b1;
    o_cs_n = ~sel;
    o_rd_n = 1'b0;
    repeat (6) @(negedge i_clk_sys);
    oe_on = i_data_oe;
    o_rd_n = 1'b1;
    repeat (4) @(negedge i_clk_sys);
    o_cs_n = 1'b1;
    repeat (4) @(negedge i_clk_sys);
    oe_off = i_data_oe;
  endtask
endmodule // sac_host_model

// file: testbench/simultaneous_adc_sequence_control_test.sv
// Self-checking bench for the sequence controller.
`timescale 1ns/100ps

module simultaneous_adc_sequence_control_test;
  logic        clk, rst, start, hs, standby_n_n, cks, ext, cs_n, rd_n, wr_n;
  logic        busy, eoc_n, first, hold, oe, psave, eoc_d, oe_on, oe_off;
  logic [3:0]  hw, dl;
  logic [11:0] res, data;
  logic [1:0]  ch;
  logic [1:0]  ch_q[$];
  int          n_mismatch, checks_done, busy_cnt, low_len, first_len;

  // The converter core returns a value that names the channel.
  assign res = 12'hA50 | {10'h000, ch};

  sac_ctrl dut_u (.i_clk_sys(clk), .i_rst(rst), .i_conversion_start_in(start),
    .i_cs_n(cs_n), .i_rd_n(rd_n), .i_wr_n(wr_n), .i_low_data_lines(dl),
    .i_hw_channel_pins(hw), .i_seq_source_select(hs), .i_standby_n(standby_n_n),
    .i_clock_source_select(cks), .i_external_conv_clock(ext), .i_conv_result(res),
    .o_busy(busy), .o_eoc_n(eoc_n), .o_first_data_flag(first), .o_hold(hold),
    .o_conv_ch(ch), .o_data(data), .o_data_oe(oe), .o_power_save(psave));

  sac_host_model host_u (.i_clk_sys(clk), .i_data_oe(oe), .o_cs_n(cs_n),
    .o_rd_n(rd_n), .o_wr_n(wr_n), .o_low_data(dl));

  // =============================================================
  // Clocks
  // System clock at 100 MHz; external conversion clock 80 ns, own phase.
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial begin
    ext = 1'b0;
    #3;
    forever #40 ext = ~ext;
  end

  // =============================================================
  // Checking and closing
  task automatic chk(input string nm, input logic [11:0] exp, input logic [11:0] got);
    checks_done++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic give_verdict;
    $display("Comparisons %0d, mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // Waits for busy to reach a level, giving up after a bounded count.
  task automatic wait_busy(input logic lvl);
    int k;
    k = 0;
    while (busy !== lvl && k < 3000) begin
      @(negedge clk);
      k++;
    end
    if (busy !== lvl) begin
      n_mismatch++;
      give_verdict();
    end
  endtask

  // =============================================================
  // End-of-conversion monitor
  // Logs the channel at each pulse, its width and the time to the first one.
  // Sampled on the falling edge, where the design's outputs have settled.
  always @(negedge clk) begin
    busy_cnt = (busy === 1'b1) ? busy_cnt + 1 : 0;
    if (eoc_d === 1'b1 && eoc_n === 1'b0) begin
      if (ch_q.size() == 0) first_len = busy_cnt;
      ch_q.push_back(ch);
    end
    if (eoc_n === 1'b0) low_len++;
    if (eoc_d === 1'b0 && eoc_n === 1'b1) begin
      chk("eoc width", 12'h008, low_len[11:0]);
      low_len = 0;
    end
    eoc_d = eoc_n;
  end

  // Runs one sequence, changes the selection mid-run, then checks the order.
  task automatic run_seq(input logic [3:0] sel, input logic [3:0] late);
    ch_q.delete();
    repeat (4) @(negedge clk);
    start = 1'b1;
    wait_busy(1'b1);
    chk("hold", 12'h001, {11'h0, hold});
    hw = late;
    host_u.write_sel(late, 1'b1);
    wait_busy(1'b0);
    start = 1'b0;
    chk("pulses", 12'($countones(sel)), 12'(ch_q.size()));
    for (int i = 0; i < 4; i++) begin
      if (sel[i] && ch_q.size() > 0) chk("channel", 12'(i), {10'h0, ch_q.pop_front()});
    end
    chk("hold end", 12'h000, {11'h0, hold});
  endtask

  // =============================================================
  // Main sequence
  initial begin
    rst = 1'b1;
    start = 1'b0;
    hs = 1'b1;
    standby_n_n = 1'b1;
    cks = 1'b0;
    hw = 4'h0;
    eoc_d = 1'b1;
    repeat (4) @(negedge clk);
    rst = 1'b0;
    chk("reset eoc", 12'h001, {11'h0, eoc_n});
    chk("reset busy", 12'h000, {11'h0, busy});
    run_seq(4'hF, 4'h5);
    chk("int time", 12'h001, {11'h0, first_len >= 64 && first_len <= 76});
    run_seq(4'h5, 4'hA);
    chk("first", 12'h001, {11'h0, first});
    chk("data", 12'hA50, data);
    host_u.read_sel(1'b0, oe_on, oe_off);
    chk("oe no cs", 12'h000, {11'h0, oe_on});
    chk("first", 12'h001, {11'h0, first});
    host_u.read_sel(1'b1, oe_on, oe_off);
    chk("oe on", 12'h001, {11'h0, oe_on});
    chk("oe off", 12'h000, {11'h0, oe_off});
    chk("first", 12'h000, {11'h0, first});
    chk("data", 12'hA52, data);
    host_u.read_sel(1'b1, oe_on, oe_off);
    chk("first", 12'h001, {11'h0, first});
    host_u.write_sel(4'h3, 1'b0);
    run_seq(4'hA, 4'h0);
    hs = 1'b0;
    hw = 4'h8;
    run_seq(4'h8, 4'h0);
    run_seq(4'h0, 4'h1);
    cks = 1'b1;
    run_seq(4'h1, 4'h1);
    chk("ext time", 12'h001, {11'h0, first_len >= 102 && first_len <= 122});
    // Standby: power save shows and a start is ignored.
    standby_n_n = 1'b0;
    repeat (6) @(negedge clk);
    chk("standby", 12'h001, {11'h0, psave});
    start = 1'b1;
    repeat (8) @(negedge clk);
    chk("busy standby", 12'h000, {11'h0, busy});
    start = 1'b0;
    standby_n_n = 1'b1;
    repeat (6) @(negedge clk);
    chk("awake", 12'h000, {11'h0, psave});
    give_verdict();
  end
endmodule // simultaneous_adc_sequence_control_test
